// >>> src/np_codec_map.svh
/*
 * Register offsets, field positions, reset values and message code values
 * for the next page message codec.
 * Assumes a 32-bit APB slave with byte addresses and one word per register.
 */
`ifndef NP_CODEC_MAP_SVH
`define NP_CODEC_MAP_SVH

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_TX_CODE 8'h04
`define OFS_TX_ARG0 8'h08
`define OFS_TX_ARG1 8'h0c
`define OFS_TX_UP0 8'h10
`define OFS_TX_UP3 8'h1c
`define OFS_STATUS 8'h20
`define OFS_RX_ARG0 8'h24
`define OFS_RX_ARG1 8'h28
`define OFS_RX_UP0 8'h30
`define OFS_RX_UP3 8'h3c

// --------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------
`define CTRL_GO 0
`define CTRL_NULL_EN 1
`define CTRL_PD_AUTO 2
`define ST_BUSY 0
`define ST_REFUSED 1
`define ST_UNREC 2
`define ST_DONE 3
`define ST_SEQ_ERR 4
`define ST_CODE_LSB 16
`define RST_NULL_EN 1'b1
`define RST_PD_AUTO 1'b0
`define RST_CODE 11'h001

// --------------------------------------------------------------
// message codes and fault type user codes
// --------------------------------------------------------------
`define MC_RSVD_LOW 11'h000
`define MC_NULL 11'h001
`define MC_TECH_ONE 11'h002
`define MC_TECH_TWO 11'h003
`define MC_FAULT 11'h004
`define MC_ORG_ID 11'h005
`define MC_XCVR_ID 11'h006
`define MC_T2 11'h007
`define MC_GIG 11'h008
`define MC_RSVD_TOP 11'h7ff
`define FAULT_TEST 11'h000
`define FAULT_LINK_LOSS 11'h001
`define FAULT_JABBER 11'h002
`define FAULT_PD 11'h003

`endif

// >>> src/np_codec_pkg.sv
/*
 * Types shared by the next page message codec.
 * Assumes the constants of np_codec_map.svh alongside.
 */
package np_codec_pkg;

	typedef logic [10:0] page_t;
	typedef logic [2:0] up_count_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_MSG = 2'b01,
		TX_UP = 2'b10
	} tx_state_e;

endpackage : np_codec_pkg

// >>> src/next_page_message_codec.sv
/*
 * Next page message codec: builds message and unformatted page streams
 * for transmit, decodes received streams into status, APB register file.
 * Assumes the negotiation page logic shares pclk and uses valid/ready.
 */
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "np_codec_map.svh"

module next_page_message_codec
	import np_codec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_page_valid,
	output page_t tx_page_data,
	output logic tx_page_is_message,
	output logic tx_page_more,
	input wire logic tx_page_ready,
	input wire logic rx_page_valid,
	input wire page_t rx_page_data,
	input wire logic rx_page_is_message,
	input wire logic pd_fault_status
);

	// --------------------------------------------------------------
	// functions
	// --------------------------------------------------------------
	function automatic up_count_t up_count(input page_t c);
		up_count_t n;
		case (c)
			`MC_TECH_ONE: n = 3'd1;
			`MC_TECH_TWO: n = 3'd2;
			`MC_FAULT: n = 3'd1;
			`MC_ORG_ID: n = 3'd4;
			`MC_XCVR_ID: n = 3'd4;
			`MC_T2: n = 3'd2;
			`MC_GIG: n = 3'd2;
			default: n = 3'd0;
		endcase
		return n;
	endfunction : up_count

	// codes 0, 2047 and every unassigned one fall outside 1..8
	function automatic logic known(input page_t c);
		return (c >= `MC_NULL) && (c <= `MC_GIG);
	endfunction : known

	function automatic page_t pack_unf(
		input page_t c,
		input logic [1:0] i,
		input logic [31:0] a0,
		input logic [19:0] a1,
		input page_t u,
		input logic pd
	);
		page_t r;
		r = u;
		case (c)
			`MC_FAULT: begin
				if (pd) begin
					r = `FAULT_PD;
				end
			end
			`MC_ORG_ID: begin
				case (i)
					2'd0: r = a0[23:13];
					2'd1: r = a0[12:2];
					2'd2: r = {a0[1:0], a1[19:11]};
					default: r = a1[10:0];
				endcase
			end
			`MC_XCVR_ID: begin
				case (i)
					2'd0: r = a0[31:21];
					2'd1: r = a0[20:10];
					2'd2: r = {a0[9:0], a1[11]};
					default: r = a1[10:0];
				endcase
			end
			default: r = u;
		endcase
		return r;
	endfunction : pack_unf

	// --------------------------------------------------------------
	// registers and state
	// --------------------------------------------------------------
	logic null_en;
	logic pd_auto;
	page_t tx_code;
	logic [31:0] tx_arg0;
	logic [19:0] tx_arg1;
	page_t tx_up [4];
	logic refused;
	logic unrec;
	logic rx_done;
	logic seq_err;
	tx_state_e tx_state;
	page_t cur_code;
	logic [1:0] tx_idx;
	logic null_pend;
	page_t rx_code;
	page_t rx_up [4];
	logic [1:0] rx_idx;
	up_count_t rx_left;
	logic rx_skip;
	logic pd_meta;
	logic pd_sync;

	// --------------------------------------------------------------
	// bus decode
	// --------------------------------------------------------------
	wire logic access = psel && penable && pready;
	wire logic wr_en = access && pwrite;
	wire logic setup_rd = psel && !penable && !pwrite;
	wire logic up_hit = (paddr[7:4] == 4'h1) || (paddr[7:4] == 4'h3);
	wire logic [1:0] up_sel = paddr[3:2];
	wire logic wr_ctrl = wr_en && (paddr == `OFS_CTRL);
	wire logic wr_status = wr_en && (paddr == `OFS_STATUS);
	wire logic go = wr_ctrl && pwdata[`CTRL_GO];
	wire logic tx_busy = (tx_state != TX_IDLE);
	wire logic go_ok = go && !tx_busy && known(tx_code);
	wire logic do_null = !go_ok && null_pend && null_en && !tx_busy;
	wire up_count_t cur_cnt = up_count(cur_code);
	wire up_count_t next_idx = 3'({1'b0, tx_idx} + 3'd1);
	wire logic last_up = (next_idx == cur_cnt);
	wire logic pd_now = pd_auto && pd_sync;
	wire logic rx_msg = rx_page_valid && rx_page_is_message;
	wire logic rx_unf = rx_page_valid && !rx_page_is_message;
	wire logic rx_store = rx_unf && !rx_skip && (rx_left != 3'd0);
	wire logic [31:0] rx_arg0 = (rx_code == `MC_ORG_ID)
		? {8'h00, rx_up[0], rx_up[1], rx_up[2][10:9]}
		: (rx_code == `MC_XCVR_ID) ? {rx_up[0], rx_up[1], rx_up[2][10:1]} : 32'h0;
	wire logic [31:0] rx_arg1 = (rx_code == `MC_ORG_ID)
		? {12'h000, rx_up[2][8:0], rx_up[3]}
		: (rx_code == `MC_XCVR_ID) ? {20'h00000, rx_up[2][0], rx_up[3]} : 32'h0;
	wire logic [31:0] status_word = {5'h00, rx_code, 11'h000, seq_err, rx_done, unrec,
		refused, tx_busy};
	logic [31:0] rd_mux;
	logic rd_bad;

	always_comb begin
		rd_mux = 32'h0;
		rd_bad = 1'b0;
		case (paddr)
			`OFS_CTRL: rd_mux = {29'h0, pd_auto, null_en, 1'b0};
			`OFS_TX_CODE: rd_mux = {21'h0, tx_code};
			`OFS_TX_ARG0: rd_mux = tx_arg0;
			`OFS_TX_ARG1: rd_mux = {12'h000, tx_arg1};
			`OFS_STATUS: rd_mux = status_word;
			`OFS_RX_ARG0: rd_mux = rx_arg0;
			`OFS_RX_ARG1: rd_mux = rx_arg1;
			default: begin
				if (paddr[1:0] == 2'b00 && paddr[7:4] == 4'h1) begin
					rd_mux = {21'h0, tx_up[up_sel]};
				end else if (paddr[1:0] == 2'b00 && paddr[7:4] == 4'h3) begin
					rd_mux = {21'h0, rx_up[up_sel]};
				end else begin
					rd_bad = 1'b1;
				end
			end
		endcase
	end

	// --------------------------------------------------------------
	// apb slave
	// --------------------------------------------------------------
	// one wait-free access phase; read data captured in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && rd_bad;
			if (setup_rd) begin
				prdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			null_en <= `RST_NULL_EN;
			pd_auto <= `RST_PD_AUTO;
			tx_code <= `RST_CODE;
			tx_arg0 <= 32'h0;
			tx_arg1 <= 20'h0;
			for (int k = 0; k < 4; k++) begin
				tx_up[k] <= 11'h000;
			end
		end else if (wr_en && !pslverr) begin
			case (paddr)
				`OFS_CTRL: begin
					null_en <= pwdata[`CTRL_NULL_EN];
					pd_auto <= pwdata[`CTRL_PD_AUTO];
				end
				`OFS_TX_CODE: tx_code <= pwdata[10:0];
				`OFS_TX_ARG0: tx_arg0 <= pwdata;
				`OFS_TX_ARG1: tx_arg1 <= pwdata[19:0];
				default: begin
					if (up_hit && paddr[7:4] == 4'h1 && paddr[1:0] == 2'b00) begin
						tx_up[up_sel] <= pwdata[10:0];
					end
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// sticky flags, set wins over write-one-to-clear
	// --------------------------------------------------------------
	wire logic set_refused = go && !go_ok;
	wire logic set_unrec = rx_msg && !known(rx_page_data);
	wire logic set_done = rx_store && (rx_left == 3'd1);
	wire logic set_seq = rx_unf && !rx_skip && (rx_left == 3'd0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused <= 1'b0;
			unrec <= 1'b0;
			rx_done <= 1'b0;
			seq_err <= 1'b0;
		end else begin
			refused <= set_refused || (refused && !(wr_status && pwdata[`ST_REFUSED]));
			unrec <= set_unrec || (unrec && !(wr_status && pwdata[`ST_UNREC]));
			rx_done <= set_done || (rx_done && !(wr_status && pwdata[`ST_DONE]));
			seq_err <= set_seq || (seq_err && !(wr_status && pwdata[`ST_SEQ_ERR]));
		end
	end

	// --------------------------------------------------------------
	// fault status input
	// --------------------------------------------------------------
	// level may come from another block's clock; two cycles of lag are harmless
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_meta <= 1'b0;
			pd_sync <= 1'b0;
		end else begin
			pd_meta <= pd_fault_status;
			pd_sync <= pd_meta;
		end
	end

	// --------------------------------------------------------------
	// transmit sequencer
	// --------------------------------------------------------------
	// a partner page seen while idle owes it an answer page
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			null_pend <= 1'b0;
		end else if (rx_page_valid && !tx_busy && !go_ok) begin
			null_pend <= 1'b1;
		end else if (go_ok || do_null || !null_en) begin
			null_pend <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= TX_IDLE;
			cur_code <= `MC_NULL;
			tx_idx <= 2'd0;
			tx_page_valid <= 1'b0;
			tx_page_data <= 11'h000;
			tx_page_is_message <= 1'b0;
			tx_page_more <= 1'b0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (go_ok) begin
						tx_state <= TX_MSG;
						cur_code <= tx_code;
						tx_page_valid <= 1'b1;
						tx_page_data <= tx_code;
						tx_page_is_message <= 1'b1;
						tx_page_more <= (up_count(tx_code) != 3'd0);
					end else if (do_null) begin
						tx_state <= TX_MSG;
						cur_code <= `MC_NULL;
						tx_page_valid <= 1'b1;
						tx_page_data <= `MC_NULL;
						tx_page_is_message <= 1'b1;
						tx_page_more <= 1'b0;
					end
					tx_idx <= 2'd0;
				end
				TX_MSG: begin
					if (tx_page_ready) begin
						if (cur_cnt == 3'd0) begin
							tx_state <= TX_IDLE;
							tx_page_valid <= 1'b0;
						end else begin
							tx_state <= TX_UP;
							tx_page_data <= pack_unf(cur_code, 2'd0, tx_arg0, tx_arg1,
								tx_up[0], pd_now);
							tx_page_is_message <= 1'b0;
							tx_page_more <= (cur_cnt > 3'd1);
						end
					end
				end
				TX_UP: begin
					if (tx_page_ready) begin
						if (last_up) begin
							tx_state <= TX_IDLE;
							tx_page_valid <= 1'b0;
							tx_page_more <= 1'b0;
						end else begin
							tx_idx <= next_idx[1:0];
							tx_page_data <= pack_unf(cur_code, next_idx[1:0], tx_arg0,
								tx_arg1, tx_up[next_idx[1:0]], 1'b0);
							tx_page_more <= (3'(next_idx + 3'd1) < cur_cnt);
						end
					end
				end
				default: begin
					tx_state <= TX_IDLE;
					tx_page_valid <= 1'b0;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// receive decoder
	// --------------------------------------------------------------
	// unknown codes leave their pages unread until the next message page
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_code <= `MC_NULL;
			rx_idx <= 2'd0;
			rx_left <= 3'd0;
			rx_skip <= 1'b0;
			for (int k = 0; k < 4; k++) begin
				rx_up[k] <= 11'h000;
			end
		end else if (rx_msg) begin
			rx_code <= rx_page_data;
			rx_idx <= 2'd0;
			rx_left <= up_count(rx_page_data);
			rx_skip <= !known(rx_page_data);
		end else if (rx_store) begin
			rx_up[rx_idx] <= rx_page_data;
			rx_idx <= 2'(rx_idx + 2'd1);
			rx_left <= 3'(rx_left - 3'd1);
		end
	end

endmodule : next_page_message_codec

// >>> dv/np_codec_chk.sv
/*
 * checker for the codec's page stream and apb answer timing.
 * assumes bind to next_page_message_codec, one clock pclk.
 */
`timescale 1ns/1ps
`include "np_codec_map.svh"
module np_codec_chk
	import np_codec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic tx_page_valid,
	input wire page_t tx_page_data,
	input wire logic tx_page_is_message,
	input wire logic tx_page_more,
	input wire logic tx_page_ready
);
	// ----
	// pages still owed after the last message page
	// ----
	logic [2:0] rem;
	wire take = tx_page_valid && tx_page_ready;
	wire msg_take = take && tx_page_is_message;
	wire up_take = take && !tx_page_is_message;
	function automatic logic [2:0] ups(input page_t c);
		case (c)
			11'h002, 11'h004: ups = 3'd1;
			11'h003, 11'h007, 11'h008: ups = 3'd2;
			11'h005, 11'h006: ups = 3'd4;
			default: ups = 3'd0;
		endcase
	endfunction : ups
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rem <= 3'd0;
		else if (msg_take)
			rem <= ups(tx_page_data);
		else if (up_take)
			rem <= rem - 3'd1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_NO_RSVD: assert property (
		tx_page_valid && tx_page_is_message |-> tx_page_data != `MC_RSVD_LOW
		&& tx_page_data != `MC_RSVD_TOP) else $error("reserved code sent");
	AST_KNOWN: assert property (
		tx_page_valid && tx_page_is_message |-> tx_page_data <= `MC_GIG)
		else $error("unassigned code sent");
	AST_HOLD: assert property (
		tx_page_valid && !tx_page_ready |=> tx_page_valid && $stable(tx_page_data)
		&& $stable(tx_page_is_message)) else $error("page dropped before taken");
	AST_UP_ANNOUNCED: assert property (
		up_take |-> rem != 3'd0) else $error("page not announced");
	AST_COUNT: assert property (
		msg_take |-> rem == 3'd0) else $error("page count short");
	AST_MORE: assert property (
		take |-> tx_page_more == (tx_page_is_message ? ups(tx_page_data) != 3'd0
		: rem > 3'd1)) else $error("more flag wrong");
	AST_END: assert property (
		$fell(tx_page_valid) |-> rem == 3'd0) else $error("stream ended early");
	AST_PREADY: assert property (
		psel && !penable |=> pready ##1 !pready) else $error("apb answer timing");
	cover property (msg_take && tx_page_data == `MC_ORG_ID);
	cover property (msg_take && tx_page_data == `MC_NULL);
	cover property (tx_page_valid && !tx_page_ready [*3]);
endmodule : np_codec_chk

bind next_page_message_codec np_codec_chk np_codec_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .tx_page_valid(tx_page_valid),
	.tx_page_data(tx_page_data), .tx_page_is_message(tx_page_is_message),
	.tx_page_more(tx_page_more), .tx_page_ready(tx_page_ready));

// >>> dv/np_link_partner.sv
/*
 * link partner model: takes offered pages, sends pages on request.
 * assumes the codec's page handshake on pclk.
 */
`timescale 1ns/1ps
module np_link_partner
	import np_codec_pkg::*;
(
	input wire logic pclk,
	input wire logic slow,
	input wire logic tx_page_valid,
	input wire page_t tx_page_data,
	input wire logic tx_page_is_message,
	output logic tx_page_ready,
	output logic rx_page_valid,
	output page_t rx_page_data,
	output logic rx_page_is_message
);
	// ----
	// page capture and sending
	// ----
	logic [1:0] ph = 2'd0;
	logic [11:0] got[$];
	initial begin
		tx_page_ready = 1'b0;
		rx_page_valid = 1'b0;
		rx_page_data = 11'h000;
		rx_page_is_message = 1'b0;
	end
	// slow grants one cycle in four
	always @(posedge pclk) begin
		ph <= ph + 2'd1;
		tx_page_ready <= !slow || ph == 2'd0;
		if (tx_page_valid && tx_page_ready)
			got.push_back({tx_page_is_message, tx_page_data});
	end
	// released lines show the inverse, not the last value
	task automatic send(input logic m, input page_t c);
		@(posedge pclk);
		rx_page_valid <= 1'b1;
		rx_page_data <= c;
		rx_page_is_message <= m;
		@(posedge pclk);
		rx_page_valid <= 1'b0;
		rx_page_data <= ~c;
		rx_page_is_message <= ~m;
	endtask : send
endmodule : np_link_partner

// >>> dv/test_next_page_message_codec.sv
/*
 * testbench: apb master, page stream model, received status model.
 * assumes np_link_partner on the page side and the bound checker.
 */
`timescale 1ns/1ps
`include "np_codec_map.svh"
module test_next_page_message_codec
	import np_codec_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pd_fault_status = 1'b0, slow = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd, a0, a1;
	logic pready, pslverr, err, tx_page_valid, tx_page_is_message, tx_page_more;
	logic tx_page_ready, rx_page_valid, rx_page_is_message;
	page_t tx_page_data, rx_page_data, e;
	page_t up[4];
	page_t bad[3] = '{11'h000, 11'h009, 11'h7ff};
	int fails = 0, check_count = 0, seed = 32'h40c2;
	int cnt[9] = '{0, 0, 1, 2, 1, 4, 4, 2, 2};
	always #2 pclk = ~pclk;
	next_page_message_codec next_page_message_codec_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_page_valid(tx_page_valid),
		.tx_page_data(tx_page_data), .tx_page_is_message(tx_page_is_message),
		.tx_page_more(tx_page_more), .tx_page_ready(tx_page_ready),
		.rx_page_valid(rx_page_valid), .rx_page_data(rx_page_data),
		.rx_page_is_message(rx_page_is_message), .pd_fault_status(pd_fault_status));
	np_link_partner partner_i (.pclk(pclk), .slow(slow), .tx_page_valid(tx_page_valid),
		.tx_page_data(tx_page_data), .tx_page_is_message(tx_page_is_message),
		.tx_page_ready(tx_page_ready), .rx_page_valid(rx_page_valid),
		.rx_page_data(rx_page_data), .rx_page_is_message(rx_page_is_message));
	// ----
	// tasks
	// ----
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk32(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			fails++;
			$display("[FAIL] %0t reg got %h exp %h", $time, g, x);
		end
	endtask : chk32
	task automatic chk_page(input logic [11:0] g, input logic [11:0] x);
		check_count++;
		if (g !== x) begin
			fails++;
			$display("[FAIL] %0t page got %h exp %h", $time, g, x);
		end
	endtask : chk_page
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk32(rd, x);
	endtask : rd_chk
	task automatic wait_pages(input int k);
		for (int i = 0; i < 300 && partner_i.got.size() < k; i++)
			@(posedge pclk);
		if (partner_i.got.size() < k) begin
			fails++;
			$display("[FAIL] %0t pages missing", $time);
		end
	endtask : wait_pages
	task automatic stop_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		fails++;
		stop_test();
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`OFS_CTRL, 32'h2);
		rd_chk(`OFS_TX_CODE, 32'h1);
		rd_chk(`OFS_STATUS, 32'h10000);
		rd_chk(8'h40, 32'h0);
		chk32({31'h0, err}, 32'h1);
		$display("reset test done");
		for (int c = 1; c <= 8; c++) begin
			a0 = $random(seed);
			a1 = $random(seed);
			slow <= c[0];
			for (int i = 0; i < 4; i++) begin
				up[i] = 11'($random(seed));
				apb(1'b1, `OFS_TX_UP0 + 8'(4 * i), {21'h0, up[i]});
			end
			pd_fault_status <= c == 4 || up[1][0];
			apb(1'b1, `OFS_TX_ARG0, a0);
			apb(1'b1, `OFS_TX_ARG1, {12'h0, a1[19:0]});
			apb(1'b1, `OFS_TX_CODE, 32'(c));
			partner_i.got.delete();
			apb(1'b1, `OFS_CTRL, 32'h7);
			wait_pages(1 + cnt[c]);
			chk_page(partner_i.got.pop_front(), {1'b1, 11'(c)});
			for (int i = 0; i < cnt[c]; i++) begin
				case (c)
					5: e = i == 0 ? a0[23:13] : i == 1 ? a0[12:2]
						: i == 2 ? {a0[1:0], a1[19:11]} : a1[10:0];
					6: e = i == 0 ? a0[31:21] : i == 1 ? a0[20:10]
						: i == 2 ? {a0[9:0], a1[11]} : a1[10:0];
					4: e = pd_fault_status ? `FAULT_PD : up[0];
					default: e = up[i];
				endcase
				chk_page(partner_i.got.pop_front(), {1'b0, e});
			end
		end
		slow <= 1'b0;
		$display("transmit test done");
		partner_i.got.delete();
		foreach (bad[k]) begin
			apb(1'b1, `OFS_TX_CODE, {21'h0, bad[k]});
			apb(1'b1, `OFS_CTRL, 32'h3);
			rd_chk(`OFS_STATUS, 32'h10002);
			apb(1'b1, `OFS_STATUS, 32'h1e);
		end
		chk32(32'(partner_i.got.size()), 32'h0);
		$display("refusal test done");
		partner_i.send(1'b1, `MC_NULL);
		wait_pages(1);
		chk_page(partner_i.got.pop_front(), {1'b1, `MC_NULL});
		apb(1'b1, `OFS_CTRL, 32'h0);
		partner_i.send(1'b1, `MC_NULL);
		repeat (20) @(posedge pclk);
		chk32(32'(partner_i.got.size()), 32'h0);
		$display("null test done");
		for (int k = 0; k < 2; k++) begin
			a0 = $random(seed);
			a1 = $random(seed);
			if (k == 0)
				a0[31:24] = 8'h00;
			apb(1'b1, `OFS_STATUS, 32'h1e);
			partner_i.send(1'b1, 11'(5 + k));
			partner_i.send(1'b0, k ? a0[31:21] : a0[23:13]);
			partner_i.send(1'b0, k ? a0[20:10] : a0[12:2]);
			partner_i.send(1'b0, k ? {a0[9:0], a1[11]} : {a0[1:0], a1[19:11]});
			partner_i.send(1'b0, a1[10:0]);
			rd_chk(`OFS_RX_ARG0, a0);
			rd_chk(`OFS_RX_ARG1, {12'h0, k ? {8'h0, a1[11:0]} : a1[19:0]});
			rd_chk(`OFS_RX_UP3, {21'h0, a1[10:0]});
			rd_chk(`OFS_STATUS, {5'h0, 11'(5 + k), 16'h8});
		end
		apb(1'b1, `OFS_STATUS, 32'h1e);
		partner_i.send(1'b0, 11'h155);
		rd_chk(`OFS_STATUS, {5'h0, 11'h6, 16'h10});
		apb(1'b1, `OFS_STATUS, 32'h1e);
		partner_i.send(1'b1, 11'h009);
		partner_i.send(1'b0, 11'h003);
		rd_chk(`OFS_STATUS, {5'h0, 11'h9, 16'h4});
		$display("receive test done");
		stop_test();
	end
endmodule : test_next_page_message_codec
